//--- hdl/fps_defines.svh
/*
 * Constants of the flash program/erase sequencer: register offsets, field
 * positions, reset values, key codes and timing counts.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
 */
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// register byte offsets
`define FPS_CTL_OFS        8'h00
`define FPS_KEY_OFS        8'h04
`define FPS_RBCN_OFS       8'h08
`define FPS_BANK_OFS       8'h0C
`define FPS_STAT_OFS       8'h10
`define FPS_SUPPLY_OFS     8'h14

// field positions
`define FPS_WE_BIT         0
`define FPS_EE_BIT         1
`define FPS_BLKW_BIT       0
`define FPS_SMON_EN_BIT    0
`define FPS_SMON_RST_BIT   1

// reset values
`define FPS_SUPPLY_RST     2'b11

// key codes
`define FPS_KEY1           8'hA5
`define FPS_KEY2           8'hF1
`define FPS_ERASED         8'hFF

// operation timing
`define FPS_PROG_NS        40000
`define FPS_ERASE_NS       20000000
`define FPS_CLK_MHZ        50
`define FPS_PROG_CYC       ((`FPS_PROG_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_ERASE_CYC      ((`FPS_ERASE_NS * `FPS_CLK_MHZ + 999) / 1000)

`endif

//--- hdl/fps_pkg.sv
/*
 * Types of the flash program/erase sequencer.
 * Assumes fps_defines.svh holds the numbers.
 */
package fps_pkg;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_HALF,
		KEY_OPEN,
		KEY_DEAD
	} fps_key_t;

	typedef enum logic [1:0] {
		OP_IDLE,
		OP_PROG,
		OP_ERASE
	} fps_op_t;

	typedef struct packed {
		logic        xdata_we;
		logic        short_addr;
		logic [15:0] addr;
		logic [7:0]  data;
	} fps_req_t;

	typedef struct packed {
		logic        we;
		logic        erase;
		logic [1:0]  bank;
		logic [15:0] addr;
		logic [31:0] data;
		logic [3:0]  lanes;
	} fps_flash_t;

endpackage : fps_pkg

//--- hdl/fps_sequencer.sv
/*
 * Flash program/erase sequencer with Wishbone registers, key lock, page
 * erase, byte and 4-byte block writes, and flash-error reset request.
 * Assumes the core raises each write for one clock and waits while stall_o is high, and that the
 * flash array performs the AND of old and new data on a program strobe.
 */
`timescale 1ns/1ps
`include "fps_defines.svh"

module fps_sequencer #(
	parameter int unsigned PROG_CYC  = `FPS_PROG_CYC,
	parameter int unsigned ERASE_CYC = `FPS_ERASE_CYC
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	input  wire logic               wb_we_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	output logic                    wb_ack_o,
	input  wire fps_pkg::fps_req_t  core_req_i,
	output logic                    ram_we_o,
	output logic                    stall_o,
	output fps_pkg::fps_flash_t     flash_o,
	output logic                    flash_error_reset_o
);

	// ****************************************
	// registers
	// ****************************************
	logic             write_en_q;
	logic             erase_en_q;
	logic             blkw_en_q;
	logic [1:0]       bank_q;
	logic [1:0]       supply_q;
	fps_pkg::fps_key_t key_q;
	fps_pkg::fps_op_t  op_q;
	logic [31:0]      cnt_q;
	logic             ack_q;
	logic [31:0]      rdat_q;
	logic [23:0]      cache_q;
	logic [2:0]       cache_vld_q;
	logic             ferr_q;
	logic             busy_seen_q;

	logic wb_req;
	logic key_wr;
	logic flash_wr;
	logic flash_go;
	logic op_done;
	logic supply_ok;
	logic blk_commit;

	assign wb_req    = wb_cyc_i && wb_stb_i && !ack_q;
	assign key_wr    = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `FPS_KEY_OFS);
	assign supply_ok = supply_q[`FPS_SMON_EN_BIT] && supply_q[`FPS_SMON_RST_BIT];
	// short-address writes above 0x00ff never reach flash
	assign flash_wr  = core_req_i.xdata_we && write_en_q && (op_q == fps_pkg::OP_IDLE) &&
	                   !(core_req_i.short_addr && (core_req_i.addr > 16'h00FF));
	assign flash_go  = flash_wr && (key_q == fps_pkg::KEY_OPEN) && supply_ok;
	assign op_done   = (op_q != fps_pkg::OP_IDLE) && (cnt_q == 32'h0000_0000);
	assign blk_commit = !blkw_en_q || (core_req_i.addr[1:0] == 2'b11);

	assign ram_we_o = core_req_i.xdata_we && !write_en_q;
	assign stall_o  = (op_q != fps_pkg::OP_IDLE);
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign flash_error_reset_o = ferr_q;

	// ****************************************
	// wishbone slave
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_req;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					`FPS_CTL_OFS:    rdat_q <= {30'h0000_0000, erase_en_q, write_en_q};
					`FPS_RBCN_OFS:   rdat_q <= {31'h0000_0000, blkw_en_q};
					`FPS_BANK_OFS:   rdat_q <= {30'h0000_0000, bank_q};
					`FPS_STAT_OFS:   rdat_q <= {28'h000_0000, busy_seen_q, op_q != fps_pkg::OP_IDLE,
					                            key_q == fps_pkg::KEY_DEAD, key_q == fps_pkg::KEY_OPEN};
					`FPS_SUPPLY_OFS: rdat_q <= {30'h0000_0000, supply_q};
					default:         rdat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			write_en_q <= 1'b0;
			erase_en_q <= 1'b0;
			blkw_en_q  <= 1'b0;
			bank_q     <= 2'b00;
			supply_q   <= `FPS_SUPPLY_RST;
		end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				`FPS_CTL_OFS: begin
					write_en_q <= wb_dat_i[`FPS_WE_BIT];
					erase_en_q <= wb_dat_i[`FPS_EE_BIT];
				end
				`FPS_RBCN_OFS:   blkw_en_q <= wb_dat_i[`FPS_BLKW_BIT];
				`FPS_BANK_OFS:   bank_q    <= wb_dat_i[1:0];
				`FPS_SUPPLY_OFS: supply_q  <= wb_dat_i[1:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// key lock
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_q <= fps_pkg::KEY_IDLE;
		end else begin
			unique case (key_q)
				fps_pkg::KEY_IDLE: begin
					if (key_wr)
						key_q <= (wb_dat_i[7:0] == `FPS_KEY1) ? fps_pkg::KEY_HALF : fps_pkg::KEY_DEAD;
					else if (flash_wr)
						key_q <= fps_pkg::KEY_DEAD;
				end
				fps_pkg::KEY_HALF: begin
					if (key_wr)
						key_q <= (wb_dat_i[7:0] == `FPS_KEY2) ? fps_pkg::KEY_OPEN : fps_pkg::KEY_DEAD;
					else if (flash_wr)
						key_q <= fps_pkg::KEY_DEAD;
				end
				fps_pkg::KEY_OPEN: begin
					if (key_wr)
						key_q <= fps_pkg::KEY_DEAD;
					else if (flash_go)
						key_q <= fps_pkg::KEY_IDLE;
				end
				fps_pkg::KEY_DEAD: key_q <= fps_pkg::KEY_DEAD;
			endcase
		end
	end

	// ****************************************
	// operation timer and block cache
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_q        <= fps_pkg::OP_IDLE;
			cnt_q       <= 32'h0000_0000;
			busy_seen_q <= 1'b0;
		end else if (flash_go && erase_en_q) begin
			op_q        <= fps_pkg::OP_ERASE;
			cnt_q       <= ERASE_CYC - 1;
			busy_seen_q <= 1'b1;
		end else if (flash_go && blk_commit) begin
			op_q        <= fps_pkg::OP_PROG;
			cnt_q       <= PROG_CYC - 1;
			busy_seen_q <= 1'b1;
		end else if (op_done) begin
			op_q <= fps_pkg::OP_IDLE;
		end else if (op_q != fps_pkg::OP_IDLE) begin
			cnt_q <= cnt_q - 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cache_q     <= 24'h00_0000;
			cache_vld_q <= 3'b000;
		end else if (!blkw_en_q || (flash_go && blk_commit)) begin
			cache_vld_q <= 3'b000;
		end else if (flash_go && !erase_en_q) begin
			unique case (core_req_i.addr[1:0])
				2'b00: begin
					cache_q[7:0]   <= core_req_i.data;
					cache_vld_q    <= 3'b001;
				end
				2'b01: begin
					cache_q[15:8]  <= core_req_i.data;
					cache_vld_q[1] <= 1'b1;
				end
				default: begin
					cache_q[23:16] <= core_req_i.data;
					cache_vld_q[2] <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// flash array strobe and error reset
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_o <= '0;
		end else begin
			flash_o.we <= flash_go && (erase_en_q || blk_commit);
			if (flash_go) begin
				flash_o.erase <= erase_en_q;
				flash_o.bank  <= bank_q;
				if (erase_en_q)
					flash_o.addr <= {core_req_i.addr[15:10], 10'h000};
				else if (blkw_en_q)
					flash_o.addr <= {core_req_i.addr[15:2], 2'b00};
				else
					flash_o.addr <= core_req_i.addr;
				if (erase_en_q) begin
					flash_o.data  <= {4{`FPS_ERASED}};
					flash_o.lanes <= 4'hF;
				end else if (blkw_en_q) begin
					flash_o.data  <= {core_req_i.data, cache_q};
					flash_o.lanes <= {1'b1, cache_vld_q};
				end else begin
					flash_o.data  <= {24'h00_0000, core_req_i.data};
					flash_o.lanes <= 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ferr_q <= 1'b0;
		else
			ferr_q <= flash_wr && (key_q == fps_pkg::KEY_OPEN) && !supply_ok;
	end

	// ****************************************
	// checks
	// ****************************************
	a_stall_len: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(stall_o) && op_q == fps_pkg::OP_PROG |-> stall_o [*2]) else $error("stall too short");
	a_stall_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		stall_o && !op_done |=> stall_o) else $error("stall dropped while timing");
	a_stall_end: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(stall_o) |-> $past(op_done)) else $error("stall ended before timer");
	a_dead_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		key_q == fps_pkg::KEY_DEAD |=> key_q == fps_pkg::KEY_DEAD) else $error("lock left dead");
	a_relock_after: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_go |=> key_q != fps_pkg::KEY_OPEN) else $error("lock not rearmed");
	a_key_order: assert property (@(posedge clk_i) disable iff (rst_i)
		key_wr && key_q == fps_pkg::KEY_HALF && wb_dat_i[7:0] == `FPS_KEY2 |=> key_q == fps_pkg::KEY_OPEN)
		else $error("second key refused");
	a_bad_key: assert property (@(posedge clk_i) disable iff (rst_i)
		key_wr && key_q == fps_pkg::KEY_IDLE && wb_dat_i[7:0] != `FPS_KEY1 |=> key_q == fps_pkg::KEY_DEAD)
		else $error("bad key accepted");
	a_early_write: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_wr && !key_wr && key_q == fps_pkg::KEY_IDLE |=> key_q == fps_pkg::KEY_DEAD)
		else $error("unkeyed write not locked");
	a_ferr_supply: assert property (@(posedge clk_i) disable iff (rst_i)
		ferr_q |-> !flash_o.we && !$past(supply_ok)) else $error("error reset wrong");
	a_ram_route: assert property (@(posedge clk_i) disable iff (rst_i)
		write_en_q |-> !ram_we_o) else $error("ram written while flash routed");
	a_short_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		core_req_i.short_addr && core_req_i.addr > 16'h00FF |-> !flash_go) else $error("short address taken");
	a_we_needed: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_o.we |-> $past(write_en_q) && (!flash_o.erase || $past(erase_en_q))) else $error("flash modified unlocked");
	a_erase_page: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_o.we && flash_o.erase |-> flash_o.addr[9:0] == 10'h000 && flash_o.data == {4{`FPS_ERASED}})
		else $error("erase not page wide");
	a_blk_commit: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_go && blkw_en_q && !erase_en_q && core_req_i.addr[1:0] == 2'b11 |=> flash_o.we && flash_o.lanes[3]
		&& flash_o.addr[1:0] == 2'b00) else $error("block not committed aligned");
	a_blk_partial: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_go && blkw_en_q && !erase_en_q && core_req_i.addr[1:0] != 2'b11 |=> !flash_o.we && !stall_o)
		else $error("partial block committed");

	c_prog: cover property (@(posedge clk_i) op_q == fps_pkg::OP_PROG && op_done);
	c_erase: cover property (@(posedge clk_i) op_q == fps_pkg::OP_ERASE && op_done);
	c_block: cover property (@(posedge clk_i) flash_o.we && flash_o.lanes == 4'hF && !flash_o.erase);
	c_dead: cover property (@(posedge clk_i) key_q == fps_pkg::KEY_DEAD);
	c_error: cover property (@(posedge clk_i) ferr_q);

endmodule : fps_sequencer

//--- verif/fps_core_model.sv
/*
 * Core model: issues external-data writes toward the sequencer, one cycle each.
 * Assumes each call starts just after a rising edge of clk_i.
 */
`timescale 1ns/1ps

module fps_core_model (
	input  wire logic         clk_i,
	input  wire logic         stall_i,
	output fps_pkg::fps_req_t req_o
);
	initial req_o = '0;

	// caller has interrupts masked
	task automatic put(input logic [15:0] a, input logic [7:0] d, input logic s);
		int n;
		req_o.addr       <= a;
		req_o.data       <= d;
		req_o.short_addr <= s;
		req_o.xdata_we   <= 1'b1;
		@(posedge clk_i);
		req_o.xdata_we <= 1'b0;
		req_o.addr     <= ~a;
		req_o.data     <= ~d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (stall_i === 1'b1 && n < 2000);
	endtask : put
endmodule : fps_core_model

//--- verif/tb.sv
/*
 * Self-checking bench of the flash program/erase sequencer.
 * Assumes fps_defines.svh offsets and a classic Wishbone slave.
 */
`timescale 1ns/1ps
`include "fps_defines.svh"

module tb;
	localparam int P = 4;
	localparam int E = 8;
	logic                clk_i;
	logic                rst_i;
	logic [7:0]          wb_adr;
	logic [31:0]         wb_dat;
	logic [31:0]         wb_q;
	logic [31:0]         rd;
	logic                wb_we;
	logic                wb_cyc;
	logic                wb_stb;
	logic                wb_ack;
	logic                ram_we;
	logic                stall;
	logic                ferr;
	logic                ram_q;
	fps_pkg::fps_req_t   req;
	fps_pkg::fps_flash_t fl;
	fps_pkg::fps_flash_t cap;
	int                  fail_count;
	int                  tests_run;
	int                  opn;
	int                  errn;
	int                  scnt;
	int                  cyc;
	int                  n0;

	fps_sequencer #(.PROG_CYC(P), .ERASE_CYC(E)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_we_i(wb_we), .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .core_req_i(req), .ram_we_o(ram_we), .stall_o(stall),
		.flash_o(fl), .flash_error_reset_o(ferr));
	fps_core_model u_core (.clk_i(clk_i), .stall_i(stall), .req_o(req));

	// ****************
	// monitors
	// ****************
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	always @(negedge clk_i) begin
		cyc++;
		if (fl.we === 1'b1) begin
			opn++;
			cap = fl;
		end
		if (stall === 1'b1) scnt = (fl.we === 1'b1) ? 1 : scnt + 1;
		if (ferr === 1'b1) errn++;
		if (req.xdata_we === 1'b1) ram_q = ram_we;
		if (cyc == 20000) begin
			$display("Error cycle_limit expected below %0d seen %0d", 20000, cyc);
			fail_count++;
			complete_run();
		end
	end

	// ****************
	// helpers
	// ****************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", nm, e, s);
			fail_count++;
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_dat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) begin
			$display("Error wb_ack expected 1 seen %b", wb_ack);
			fail_count++;
		end
		rd = wb_q;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask : rc

	task automatic keys;
		wr(`FPS_KEY_OFS, 32'h0000_00A5);
		wr(`FPS_KEY_OFS, 32'h0000_00F1);
	endtask : keys

	task automatic reset(input logic [31:0] ctl);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wr(`FPS_CTL_OFS, ctl);
		n0 = opn;
	endtask : reset

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// ****************
	// scenarios
	// ****************
	task automatic t_byte;
		reset(32'h0000_0000);
		rc("supply", `FPS_SUPPLY_OFS, 32'h0000_0003);
		rc("unmapped", 8'h18, 32'h0000_0000);
		wr(`FPS_CTL_OFS, 32'h0000_0001);
		keys();
		u_core.put(16'h1234, 8'h5A, 1'b0);
		chk("ops", 32'd1, 32'(opn - n0));
		chk("addr", 32'h0000_1234, 32'(cap.addr));
		chk("data", 32'h0000_005A, cap.data);
		chk("lanes", 32'h0000_0001, 32'(cap.lanes));
		chk("stall", 32'(P), 32'(scnt));
		chk("ram_we", 32'h0, 32'(ram_q));
		rc("ctl", `FPS_CTL_OFS, 32'h0000_0001);
		u_core.put(16'h1235, 8'h00, 1'b0);
		chk("relock", 32'd1, 32'(opn - n0));
		$display("done byte");
	endtask : t_byte

	task automatic t_erase;
		reset(32'h0000_0003);
		wr(`FPS_BANK_OFS, 32'h0000_0002);
		keys();
		u_core.put(16'h0A37, 8'h00, 1'b0);
		chk("erase", 32'h1, 32'(cap.erase));
		chk("bank", 32'h2, 32'(cap.bank));
		chk("page", 32'h0000_0800, 32'(cap.addr));
		chk("fill", 32'hFFFF_FFFF, cap.data);
		chk("stall", 32'(E), 32'(scnt));
		$display("done erase");
	endtask : t_erase

	task automatic t_block;
		reset(32'h0000_0001);
		wr(`FPS_RBCN_OFS, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			keys();
			chk("cached", 32'd0, 32'(opn - n0));
			u_core.put(16'h0104 + 16'(i), 8'h10 + 8'(i), 1'b0);
		end
		chk("commit", 32'd1, 32'(opn - n0));
		chk("bdata", 32'h1312_1110, cap.data);
		chk("blanes", 32'h0000_000F, 32'(cap.lanes));
		chk("baddr", 32'h0000_0104, 32'(cap.addr));
		chk("bstall", 32'(P), 32'(scnt));
		for (int i = 0; i < 3; i++) begin
			keys();
			u_core.put(16'h0200 + 16'(i), 8'h00, 1'b0);
		end
		wr(`FPS_RBCN_OFS, 32'h0000_0000);
		chk("discard", 32'd1, 32'(opn - n0));
		wr(`FPS_RBCN_OFS, 32'h0000_0001);
		keys();
		u_core.put(16'h0203, 8'h33, 1'b0);
		chk("dlanes", 32'h0000_0008, 32'(cap.lanes));
		chk("dcount", 32'd2, 32'(opn - n0));
		$display("done block");
	endtask : t_block

	task automatic t_guard;
		reset(32'h0000_0000);
		u_core.put(16'h0300, 8'h11, 1'b0);
		chk("to_ram", 32'h1, 32'(ram_q));
		reset(32'h0000_0002);
		keys();
		u_core.put(16'h0300, 8'h11, 1'b0);
		chk("ee_only", 32'd0, 32'(opn - n0));
		reset(32'h0000_0001);
		keys();
		u_core.put(16'h0120, 8'h11, 1'b1);
		chk("short_hi", 32'd0, 32'(opn - n0));
		reset(32'h0000_0001);
		keys();
		u_core.put(16'h0080, 8'h11, 1'b1);
		chk("short_lo", 32'd1, 32'(opn - n0));
		$display("done guard");
	endtask : t_guard

	task automatic t_lock;
		int e0;
		for (int s = 0; s < 3; s++) begin
			reset(32'h0000_0001);
			wr(`FPS_SUPPLY_OFS, 32'(s));
			keys();
			e0 = errn;
			u_core.put(16'h0400, 8'h00, 1'b0);
			chk("ferr", 32'd1, 32'(errn - e0));
			chk("fop", 32'd0, 32'(opn - n0));
		end
		reset(32'h0000_0001);
		wr(`FPS_KEY_OFS, 32'h0000_00A5);
		wr(`FPS_KEY_OFS, 32'h0000_00A4);
		keys();
		u_core.put(16'h0400, 8'h00, 1'b0);
		chk("badkey", 32'd0, 32'(opn - n0));
		rc("stat_dead", `FPS_STAT_OFS, 32'h0000_0002);
		reset(32'h0000_0001);
		u_core.put(16'h0400, 8'h00, 1'b0);
		keys();
		u_core.put(16'h0400, 8'h00, 1'b0);
		chk("early", 32'd0, 32'(opn - n0));
		reset(32'h0000_0001);
		keys();
		u_core.put(16'h0400, 8'h00, 1'b0);
		chk("rearm", 32'd1, 32'(opn - n0));
		rc("stat_done", `FPS_STAT_OFS, 32'h0000_0008);
		$display("done lock");
	endtask : t_lock

	initial begin
		rst_i      = 1'b1;
		wb_adr     = 8'h00;
		wb_dat     = 32'h0000_0000;
		wb_we      = 1'b0;
		wb_cyc     = 1'b0;
		wb_stb     = 1'b0;
		fail_count = 0;
		tests_run  = 0;
		opn        = 0;
		errn       = 0;
		scnt       = 0;
		cyc        = 0;
		@(posedge clk_i);
		t_byte();
		t_erase();
		t_block();
		t_guard();
		t_lock();
		complete_run();
	end
endmodule : tb
